// file: verilog/deviation_monitor_pkg.sv
// constants, types and register map of the linear servo deviation monitor
package deviation_monitor_pkg;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POS_LIM = 8'h04;
    localparam logic [7:0] OFS_SPD_LIM = 8'h08;
    localparam logic [7:0] OFS_THR_LIM = 8'h0c;
    localparam logic [7:0] OFS_ALARM = 8'h10;
    localparam logic [7:0] OFS_SW_RESET = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h20;

    // ==========================================================
    // field layout
    localparam int SEL_W = 3;
    localparam int SEL_LSB = 0;
    localparam int POLICY_BIT = 3;
    localparam int SEL_POS_BIT = 0;
    localparam int SEL_SPD_BIT = 1;
    localparam int SEL_THR_BIT = 2;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h3;
    localparam logic POLICY_RST = 1'b0;
    localparam int SWRST_BIT = 0;
    localparam int ALM_ACTIVE_BIT = 0;
    localparam int ALM_CODE_LSB = 4;
    localparam int ALM_TRIP_LSB = 8;
    localparam int N_CHK = 3;

    // ==========================================================
    // deviation limits: width, range and reset value
    localparam int POS_LIM_W = 10;
    localparam int POS_LIM_MIN = 1;
    localparam int POS_LIM_MAX = 1000;
    localparam int POS_LIM_RST = 50;
    localparam int SPD_LIM_W = 13;
    localparam int SPD_LIM_MIN = 1;
    localparam int SPD_LIM_MAX = 5000;
    localparam int SPD_LIM_RST = 1000;
    localparam int THR_LIM_W = 10;
    localparam int THR_LIM_MIN = 1;
    localparam int THR_LIM_MAX = 1000;
    localparam int THR_LIM_RST = 100;

    // ==========================================================
    // types
    localparam int FB_W = 32;

    typedef enum logic [1:0] {
        CODE_NONE = 2'h0,
        CODE_POS = 2'h1,
        CODE_SPD = 2'h2,
        CODE_THR = 2'h3
    } alarm_code_e;

    // model value and measured value of one quantity
    typedef struct packed {
        logic signed [FB_W-1:0] model;
        logic signed [FB_W-1:0] meas;
    } fb_pair_s;

    typedef struct packed {
        logic active;
        alarm_code_e code;
    } alarm_s;

endpackage : deviation_monitor_pkg

// file: verilog/deviation_limit_reg.sv
// one software-written deviation limit with range-checked writes
`timescale 1ns/1ps
module deviation_limit_reg import deviation_monitor_pkg::*; #(
    parameter int LW = 10,
    parameter int LMIN = 1,
    parameter int LMAX = 1000,
    parameter int LRST = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire logic [31:0] wdata,
    output logic refused,
    output logic [LW-1:0] value_ff
);

    localparam logic [LW-1:0] RST_V = LW'(LRST);

    if (LMIN < 1 || LMAX >= 2**LW || LRST < LMIN || LRST > LMAX) begin : g_chk
        $error("deviation_limit_reg: range does not fit width");
    end

    // ==========================================================
    // a value outside the legal range is refused and the old one kept
    wire in_range = (wdata >= 32'(LMIN)) && (wdata <= 32'(LMAX));
    assign refused = !in_range;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_ff <= RST_V;
        end else if (wr && in_range) begin
            value_ff <= wdata[LW-1:0];
        end
    end

endmodule : deviation_limit_reg

// file: verilog/deviation_checker.sv
// magnitude comparator: trips when |model - measured| >= limit
`timescale 1ns/1ps
module deviation_checker import deviation_monitor_pkg::*; #(
    parameter int LW = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire fb_pair_s pair,
    input wire logic [LW-1:0] limit,
    output logic trip_ff
);

    if (LW < 1 || LW > FB_W) begin : g_chk
        $error("deviation_checker: limit width out of range");
    end

    // ==========================================================
    // one extra bit so the difference of two extremes cannot wrap
    logic signed [FB_W:0] diff;
    logic [FB_W:0] mag;
    assign diff = {pair.model[FB_W-1], pair.model} - {pair.meas[FB_W-1], pair.meas};
    assign mag = diff[FB_W] ? (FB_W+1)'(-diff) : diff;
    wire over = mag >= (FB_W+1)'(limit);

    // registered so the alarm path sees a clean one-cycle decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_ff <= 1'b0;
        end else begin
            trip_ff <= enable && over;
        end
    end

endmodule : deviation_checker

// file: verilog/linear_servo_deviation_monitor.sv
// top of the linear servo deviation monitor: apb registers, checks, alarm latch, interrupt
//
// Overview of operation
// - three independent checks (position, speed, thrust) each run only when its select bit is set.
// - select bit weight 1 enables the position check, so value 1 runs it alone.
// - select bit weight 2 enables the speed check, so value 2 runs it alone.
// - select bit weight 4 enables the thrust check, so value 4 runs it alone.
// - values 3, 5, 6 and 7 run the checks of their set bits together and any may alarm.
// - after reset the select value is 3, position and speed on, thrust off.
// - position deviation at or above its 1..1000 mm limit raises sub-code 1 and stops the motor.
// - the position limit resets to 50 mm.
// - speed deviation at or above its 1..5000 mm/s limit raises sub-code 2 and stops the motor.
// - the speed limit resets to 1000 mm/s.
// - thrust deviation at or above its 1..1000 % limit raises sub-code 3 and stops the motor.
// - the thrust limit resets to 100 %.
// - with clear policy 1 a controller reset clears the alarm, with 0 only power-up or software reset.
`timescale 1ns/1ps
module linear_servo_deviation_monitor import deviation_monitor_pkg::*; #(
    parameter int DATA_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fb_pair_s pos_pair,
    input wire fb_pair_s spd_pair,
    input wire fb_pair_s thr_pair,
    input wire logic ctrl_reset_req,
    output alarm_s alarm,
    output logic motor_stop,
    output logic irq
);

    if (DATA_W != 32) begin : g_chk
        $error("linear_servo_deviation_monitor: only 32-bit apb data is served");
    end

    // ==========================================================
    // apb slave timing
    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic nxt_pready;

    // pready comes one cycle into the access phase so data and error are registered
    assign nxt_pready = psel && penable && !pready_ff;
    wire apb_done = psel && penable && pready_ff;
    wire wr_done = apb_done && pwrite;

    // address decode
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_pos = paddr == OFS_POS_LIM;
    wire hit_spd = paddr == OFS_SPD_LIM;
    wire hit_thr = paddr == OFS_THR_LIM;
    wire hit_alarm = paddr == OFS_ALARM;
    wire hit_swrst = paddr == OFS_SW_RESET;
    wire hit_istat = paddr == OFS_IRQ_STAT;
    wire hit_iclr = paddr == OFS_IRQ_CLR;
    wire hit_ien = paddr == OFS_IRQ_EN;
    wire mapped = hit_ctrl | hit_pos | hit_spd | hit_thr | hit_alarm | hit_swrst | hit_istat | hit_iclr | hit_ien;

    // ==========================================================
    // control register: select and clear policy
    logic [SEL_W-1:0] sel_ff;
    logic policy_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= SEL_RST;
            policy_ff <= POLICY_RST;
        end else if (wr_done && hit_ctrl) begin
            sel_ff <= pwdata[SEL_LSB +: SEL_W];
            policy_ff <= pwdata[POLICY_BIT];
        end
    end

    // ==========================================================
    // deviation limits, each refusing out-of-range writes
    logic [POS_LIM_W-1:0] pos_lim;
    logic [SPD_LIM_W-1:0] spd_lim;
    logic [THR_LIM_W-1:0] thr_lim;
    logic pos_ref;
    logic spd_ref;
    logic thr_ref;

    deviation_limit_reg #(
        .LW(POS_LIM_W), .LMIN(POS_LIM_MIN), .LMAX(POS_LIM_MAX), .LRST(POS_LIM_RST)
    ) u_pos_lim (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_done && hit_pos),
        .wdata(pwdata),
        .refused(pos_ref),
        .value_ff(pos_lim)
    );

    deviation_limit_reg #(
        .LW(SPD_LIM_W), .LMIN(SPD_LIM_MIN), .LMAX(SPD_LIM_MAX), .LRST(SPD_LIM_RST)
    ) u_spd_lim (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_done && hit_spd),
        .wdata(pwdata),
        .refused(spd_ref),
        .value_ff(spd_lim)
    );

    deviation_limit_reg #(
        .LW(THR_LIM_W), .LMIN(THR_LIM_MIN), .LMAX(THR_LIM_MAX), .LRST(THR_LIM_RST)
    ) u_thr_lim (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_done && hit_thr),
        .wdata(pwdata),
        .refused(thr_ref),
        .value_ff(thr_lim)
    );

    // a refused limit write is answered with pslverr
    wire lim_refused = pwrite && ((hit_pos && pos_ref) || (hit_spd && spd_ref) || (hit_thr && thr_ref));

    // ==========================================================
    // the three comparisons, each gated by its own select bit
    logic [N_CHK-1:0] trip;

    deviation_checker #(.LW(POS_LIM_W)) u_pos_chk (
        .pclk(pclk),
        .presetn(presetn),
        .enable(sel_ff[SEL_POS_BIT]),
        .pair(pos_pair),
        .limit(pos_lim),
        .trip_ff(trip[SEL_POS_BIT])
    );

    deviation_checker #(.LW(SPD_LIM_W)) u_spd_chk (
        .pclk(pclk),
        .presetn(presetn),
        .enable(sel_ff[SEL_SPD_BIT]),
        .pair(spd_pair),
        .limit(spd_lim),
        .trip_ff(trip[SEL_SPD_BIT])
    );

    deviation_checker #(.LW(THR_LIM_W)) u_thr_chk (
        .pclk(pclk),
        .presetn(presetn),
        .enable(sel_ff[SEL_THR_BIT]),
        .pair(thr_pair),
        .limit(thr_lim),
        .trip_ff(trip[SEL_THR_BIT])
    );

    // ==========================================================
    // controller reset request from the pin: two-stage sync, then rising edge
    logic creq_meta_ff;
    logic creq_sync_ff;
    logic creq_prev_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            creq_meta_ff <= 1'b0;
            creq_sync_ff <= 1'b0;
            creq_prev_ff <= 1'b0;
        end else begin
            creq_meta_ff <= ctrl_reset_req;
            creq_sync_ff <= creq_meta_ff;
            creq_prev_ff <= creq_sync_ff;
        end
    end

    wire creq_pulse = creq_sync_ff && !creq_prev_ff;

    // ==========================================================
    // alarm latch: first tripping method wins, position before speed before thrust
    alarm_s alarm_ff;
    alarm_s nxt_alarm;
    wire any_trip = |trip;
    wire sw_clr = wr_done && hit_swrst && pwdata[SWRST_BIT];
    wire alarm_clr = sw_clr || (policy_ff && creq_pulse);
    wire alarm_keep = alarm_ff.active && !alarm_clr;

    alarm_code_e trip_code;
    assign trip_code = trip[SEL_POS_BIT] ? CODE_POS :
                       trip[SEL_SPD_BIT] ? CODE_SPD :
                       trip[SEL_THR_BIT] ? CODE_THR : CODE_NONE;

    // a trip in the clearing cycle re-arms the alarm, so no event is lost
    assign nxt_alarm = '{active: alarm_keep || any_trip, code: alarm_keep ? alarm_ff.code : trip_code};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_ff <= '{active: 1'b0, code: CODE_NONE};
        end else begin
            alarm_ff <= nxt_alarm;
        end
    end

    assign alarm = alarm_ff;
    assign motor_stop = alarm_ff.active;

    // ==========================================================
    // interrupt: sticky per-method status, write-one-to-clear, enable mask
    logic [N_CHK-1:0] irq_stat_ff;
    logic [N_CHK-1:0] irq_en_ff;
    logic irq_ff;
    wire [N_CHK-1:0] irq_clr = (wr_done && hit_iclr) ? pwdata[N_CHK-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= '0;
            irq_en_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= trip | (irq_stat_ff & ~irq_clr);
            if (wr_done && hit_ien) begin
                irq_en_ff <= pwdata[N_CHK-1:0];
            end
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    assign irq = irq_ff;

    // ==========================================================
    // read mux; write-only words read as zero
    logic [DATA_W-1:0] rd_mux;
    assign rd_mux = hit_ctrl ? DATA_W'({policy_ff, sel_ff}) :
                    hit_pos ? DATA_W'(pos_lim) :
                    hit_spd ? DATA_W'(spd_lim) :
                    hit_thr ? DATA_W'(thr_lim) :
                    hit_alarm ? (DATA_W'(alarm_ff.active) << ALM_ACTIVE_BIT) |
                                (DATA_W'(alarm_ff.code) << ALM_CODE_LSB) |
                                (DATA_W'(trip) << ALM_TRIP_LSB) :
                    hit_istat ? DATA_W'(irq_stat_ff) :
                    hit_ien ? DATA_W'(irq_en_ff) : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pready && (!mapped || lim_refused);
            prdata_ff <= (nxt_pready && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ==========================================================
    // checks next to the logic
    sequence s_pos_first;
        trip[SEL_POS_BIT] && !alarm_ff.active;
    endsequence

    sequence s_ctrl_clear;
        creq_pulse && policy_ff && !any_trip;
    endsequence

    property p_pos_alarm;
        @(posedge pclk) disable iff (!presetn)
        s_pos_first |=> alarm_ff.active && alarm_ff.code == CODE_POS && motor_stop;
    endproperty
    a_pos_alarm: assert property (p_pos_alarm) else $error("position trip gave no code 1 alarm");

    property p_spd_alarm;
        @(posedge pclk) disable iff (!presetn)
        trip[SEL_SPD_BIT] && !trip[SEL_POS_BIT] && !alarm_ff.active |=> alarm_ff.code == CODE_SPD;
    endproperty
    a_spd_alarm: assert property (p_spd_alarm) else $error("speed trip gave no code 2 alarm");

    property p_thr_alarm;
        @(posedge pclk) disable iff (!presetn)
        trip == 3'h4 && !alarm_ff.active |=> alarm_ff.active && alarm_ff.code == CODE_THR;
    endproperty
    a_thr_alarm: assert property (p_thr_alarm) else $error("thrust trip gave no code 3 alarm");

    property p_pos_off;
        @(posedge pclk) disable iff (!presetn)
        !$past(sel_ff[SEL_POS_BIT]) |-> !trip[SEL_POS_BIT];
    endproperty
    a_pos_off: assert property (p_pos_off) else $error("disabled position check tripped");

    property p_spd_off;
        @(posedge pclk) disable iff (!presetn)
        !$past(sel_ff[SEL_SPD_BIT]) |-> !trip[SEL_SPD_BIT];
    endproperty
    a_spd_off: assert property (p_spd_off) else $error("disabled speed check tripped");

    property p_thr_off;
        @(posedge pclk) disable iff (!presetn)
        !$past(sel_ff[SEL_THR_BIT]) |-> !trip[SEL_THR_BIT];
    endproperty
    a_thr_off: assert property (p_thr_off) else $error("disabled thrust check tripped");

    property p_latched;
        @(posedge pclk) disable iff (!presetn)
        alarm_ff.active && !sw_clr && !(policy_ff && creq_pulse) |=> alarm_ff.active && $stable(alarm_ff.code);
    endproperty
    a_latched: assert property (p_latched) else $error("alarm dropped without a clear");

    property p_ctrl_clear;
        @(posedge pclk) disable iff (!presetn)
        alarm_ff.active ##0 s_ctrl_clear |=> !alarm_ff.active && !motor_stop;
    endproperty
    a_ctrl_clear: assert property (p_ctrl_clear) else $error("controller reset did not clear alarm");

    property p_policy_hold;
        @(posedge pclk) disable iff (!presetn)
        alarm_ff.active && !policy_ff && !sw_clr |=> alarm_ff.active;
    endproperty
    a_policy_hold: assert property (p_policy_hold) else $error("alarm cleared against clear policy");

    property p_sw_clear;
        @(posedge pclk) disable iff (!presetn)
        sw_clr && !any_trip |=> !alarm_ff.active;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("software reset did not clear alarm");

    property p_any_alarm;
        @(posedge pclk) disable iff (!presetn)
        any_trip && !alarm_ff.active |=> alarm_ff.active && motor_stop;
    endproperty
    a_any_alarm: assert property (p_any_alarm) else $error("enabled trip raised no alarm");

    // a later trip of another method must not overwrite the first code
    property p_first_kept;
        @(posedge pclk) disable iff (!presetn)
        alarm_ff.active && any_trip && !alarm_clr |=> $stable(alarm_ff.code);
    endproperty
    a_first_kept: assert property (p_first_kept) else $error("later trip replaced alarm code");

    property p_answer_once;
        @(posedge pclk) disable iff (!presetn)
        pready_ff |=> !pready_ff;
    endproperty
    a_answer_once: assert property (p_answer_once) else $error("pready stood more than one cycle");

endmodule : linear_servo_deviation_monitor

// file: dv/servo_feedback_model.sv
// feedback model of the linear motor: model and measured position, speed and thrust
`timescale 1ns/1ps
module servo_feedback_model import deviation_monitor_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic motor_stop,
    input wire logic signed [FB_W-1:0] pos_err,
    input wire logic signed [FB_W-1:0] spd_err,
    input wire logic signed [FB_W-1:0] thr_err,
    output fb_pair_s pos_pair,
    output fb_pair_s spd_pair,
    output fb_pair_s thr_pair
);
    localparam logic signed [FB_W-1:0] RUN_SPEED = 32'sh0000_0064;
    localparam logic signed [FB_W-1:0] RUN_THRUST = 32'sh0000_0032;
    logic signed [FB_W-1:0] pos_ff;
    logic signed [FB_W-1:0] speed;

    // ==========================================================
    // carriage travels steadily and halts once the drive stops the motor
    assign speed = motor_stop ? '0 : RUN_SPEED;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff <= '0;
        end else begin
            pos_ff <= pos_ff + speed;
        end
    end

    // ==========================================================
    // measured values stray from the model by the offsets the bench injects
    assign pos_pair = '{model: pos_ff, meas: pos_ff + pos_err};
    assign spd_pair = '{model: speed, meas: speed + spd_err};
    assign thr_pair = '{model: RUN_THRUST, meas: RUN_THRUST + thr_err};
endmodule : servo_feedback_model

// file: dv/tb.sv
// self-checking bench of the linear servo deviation monitor
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tb import deviation_monitor_pkg::*; ;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fb_pair_s pos_pair;
    fb_pair_s spd_pair;
    fb_pair_s thr_pair;
    logic ctrl_reset_req = 1'b0;
    alarm_s alarm;
    logic motor_stop;
    logic irq;
    logic signed [FB_W-1:0] pos_err = '0;
    logic signed [FB_W-1:0] spd_err = '0;
    logic signed [FB_W-1:0] thr_err = '0;
    int n_errors = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;
    int lim[3] = '{POS_LIM_RST, SPD_LIM_RST, THR_LIM_RST};

    always #5 pclk = ~pclk;

    linear_servo_deviation_monitor u_linear_servo_deviation_monitor (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pos_pair(pos_pair), .spd_pair(spd_pair), .thr_pair(thr_pair),
        .ctrl_reset_req(ctrl_reset_req), .alarm(alarm), .motor_stop(motor_stop), .irq(irq)
    );
    servo_feedback_model u_servo_feedback_model (
        .pclk(pclk), .presetn(presetn), .motor_stop(motor_stop), .pos_err(pos_err),
        .spd_err(spd_err), .thr_err(thr_err), .pos_pair(pos_pair), .spd_pair(spd_pair),
        .thr_pair(thr_pair)
    );

    // ==========================================================
    // apb master: request held until pready is seen at a rising edge
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // offset on one quantity, then enough edges for trip, alarm and irq to land
    task automatic set_err(input int q, input logic signed [FB_W-1:0] v);
        @(posedge pclk);
        case (q)
            0: pos_err <= v;
            1: spd_err <= v;
            default: thr_err <= v;
        endcase
        repeat (4) @(posedge pclk);
    endtask : set_err

    task automatic pulse_ctrl_reset;
        @(posedge pclk);
        ctrl_reset_req <= 1'b1;
        repeat (3) @(posedge pclk);
        ctrl_reset_req <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse_ctrl_reset

    // ==========================================================
    // scenarios
    task automatic t_reset;
        apb(OFS_CTRL, 1'b0, '0);
        `CHK("ctrl", 4'h3, rd[3:0])
        apb(OFS_POS_LIM, 1'b0, '0);
        `CHK("pos_lim", 32'h0000_0032, rd)
        apb(OFS_SPD_LIM, 1'b0, '0);
        `CHK("spd_lim", 32'h0000_03e8, rd)
        apb(OFS_THR_LIM, 1'b0, '0);
        `CHK("thr_lim", 32'h0000_0064, rd)
        `CHK("alarm", 3'h0, alarm)
        $display("test reset done");
    endtask : t_reset

    // every nonzero select value against each quantity at exactly its limit, negative sign
    task automatic t_select;
        logic [2:0] sel;
        for (int s = 1; s < 8; s++) begin
            sel = 3'(s);
            apb(OFS_CTRL, 1'b1, 32'(sel));
            for (int q = 0; q < 3; q++) begin
                set_err(q, -lim[q]);
                `CHK("active", sel[q], alarm.active)
                `CHK("motor_stop", sel[q], motor_stop)
                if (sel[q]) `CHK("code", 2'(q + 1), alarm.code)
                set_err(q, 0);
                apb(OFS_SW_RESET, 1'b1, 32'h0000_0001);
                repeat (2) @(posedge pclk);
                `CHK("cleared", 1'b0, alarm.active)
            end
        end
        $display("test select done");
    endtask : t_select

    // one below the limit, positive sign, all checks on: no alarm
    task automatic t_below;
        apb(OFS_CTRL, 1'b1, 32'h0000_0007);
        for (int q = 0; q < 3; q++) begin
            set_err(q, lim[q] - 1);
            `CHK("below", 1'b0, alarm.active)
            set_err(q, 0);
        end
        $display("test below done");
    endtask : t_below

    task automatic t_latch_policy;
        apb(OFS_CTRL, 1'b1, 32'h0000_0001);
        set_err(0, lim[0]);
        set_err(0, 0);
        apb(OFS_ALARM, 1'b0, '0);
        `CHK("alarm_reg", 11'h011, rd[10:0])
        pulse_ctrl_reset();
        `CHK("kept", 1'b1, alarm.active)
        apb(OFS_CTRL, 1'b1, 32'h0000_0009);
        pulse_ctrl_reset();
        `CHK("ctrl_clear", 1'b0, alarm.active)
        $display("test latch_policy done");
    endtask : t_latch_policy

    task automatic t_irq;
        apb(OFS_CTRL, 1'b1, 32'h0000_0003);
        // earlier scenarios left sticky status behind
        apb(OFS_IRQ_CLR, 1'b1, 32'h0000_0007);
        apb(OFS_IRQ_EN, 1'b1, 32'h0000_0001);
        set_err(1, lim[1]);
        `CHK("irq_masked", 1'b0, irq)
        `CHK("code", CODE_SPD, alarm.code)
        apb(OFS_IRQ_EN, 1'b1, 32'h0000_0002);
        apb(OFS_IRQ_STAT, 1'b0, '0);
        `CHK("irq_stat", 3'h2, rd[2:0])
        `CHK("irq", 1'b1, irq)
        set_err(1, 0);
        apb(OFS_SW_RESET, 1'b1, 32'h0000_0001);
        apb(OFS_IRQ_CLR, 1'b1, 32'h0000_0002);
        apb(OFS_IRQ_STAT, 1'b0, '0);
        `CHK("irq_stat_clr", 3'h0, rd[2:0])
        repeat (2) @(posedge pclk);
        `CHK("irq_low", 1'b0, irq)
        $display("test irq done");
    endtask : t_irq

    // range edges of each limit, then a trip at the new thrust limit
    task automatic t_limits;
        logic [ADDR_W-1:0] ofs[3] = '{OFS_POS_LIM, OFS_SPD_LIM, OFS_THR_LIM};
        int mx[3] = '{POS_LIM_MAX, SPD_LIM_MAX, THR_LIM_MAX};
        for (int q = 0; q < 3; q++) begin
            apb(ofs[q], 1'b1, 32'(mx[q]));
            `CHK("max_ok", 1'b0, err)
            apb(ofs[q], 1'b1, 32'(mx[q] + 1));
            `CHK("over_refused", 1'b1, err)
            apb(ofs[q], 1'b1, 32'h0000_0000);
            `CHK("zero_refused", 1'b1, err)
            apb(ofs[q], 1'b0, '0);
            `CHK("lim_kept", 32'(mx[q]), rd)
        end
        apb(8'h24, 1'b0, '0);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_rd", 32'h0000_0000, rd)
        apb(OFS_CTRL, 1'b1, 32'h0000_0004);
        set_err(2, -(mx[2] - 1));
        `CHK("thr_below", 1'b0, alarm.active)
        set_err(2, mx[2]);
        `CHK("thr_code", CODE_THR, alarm.code)
        $display("test limits done");
    endtask : t_limits

    // a power cycle clears a latched alarm under policy 0 and restores defaults
    task automatic t_power;
        `CHK("pre_alarm", 1'b1, alarm.active)
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("power_clear", 1'b0, alarm.active)
        apb(OFS_CTRL, 1'b0, '0);
        `CHK("ctrl_rst", 4'h3, rd[3:0])
        $display("test power done");
    endtask : t_power

    // ==========================================================
    // verdict, reached from the main sequence or the watchdog
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_select();
        t_below();
        t_latch_policy();
        t_irq();
        t_limits();
        t_power();
        tally_and_finish();
    end

    // the run needs under a thousand cycles; far more means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        tally_and_finish();
    end
endmodule : tb
